//--- design/zolc_pkg.sv
// Zero-overhead loop controller: register map, field layouts, reset values
package zolc_pkg;

  localparam int NUM_LOOPS = 2;
  localparam int ADDR_W = 32;
  localparam int CNT_W = 32;
  localparam int CSR_IDX_W = 3;

  localparam logic [ADDR_W-1:0] INSTR_BYTES = 32'h0000_0004;
  localparam logic [CNT_W-1:0] CNT_ONE = 32'h0000_0001;
  localparam logic [CNT_W-1:0] CNT_ZERO = 32'h0000_0000;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 32'h0000_0000;

  // Loop register words, three per set, in CSR and bus order
  localparam logic [CSR_IDX_W-1:0] IDX_BEGIN0 = 3'h0;
  localparam logic [CSR_IDX_W-1:0] IDX_FINISH0 = 3'h1;
  localparam logic [CSR_IDX_W-1:0] IDX_COUNT0 = 3'h2;
  localparam logic [CSR_IDX_W-1:0] IDX_BEGIN1 = 3'h3;
  localparam logic [CSR_IDX_W-1:0] IDX_FINISH1 = 3'h4;
  localparam logic [CSR_IDX_W-1:0] IDX_COUNT1 = 3'h5;
  localparam logic [11:0] CSR_WORDS = 12'h006;

  // Bus byte offsets
  localparam logic [7:0] OFS_LOOP_FIRST = 8'h00;
  localparam logic [7:0] OFS_LOOP_LAST = 8'h14;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h18;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h1C;
  localparam logic [7:0] OFS_CTRL = 8'h20;

  // Interrupt status / mask layout
  localparam int IRQ_W = 3;
  localparam int IRQ_DONE0_BIT = 0;
  localparam int IRQ_DONE1_BIT = 1;
  localparam int IRQ_ILLEGAL_BIT = 2;
  localparam logic [IRQ_W-1:0] IRQ_STATUS_RESET = 3'h0;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 3'h0;

  // Control layout
  localparam int CTRL_W = 1;
  localparam int CTRL_EN_BIT = 0;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 1'h1;

  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  typedef enum logic [1:0] {
    ZOLC_SETUP_BEGIN,
    ZOLC_SETUP_FINISH,
    ZOLC_SETUP_COUNT,
    ZOLC_SETUP_ALL
  } zolc_setup_kind_t;

  typedef struct packed {
    logic valid;
    logic loop_sel;
    zolc_setup_kind_t kind;
    logic [ADDR_W-1:0] loop_begin_addr;
    logic [ADDR_W-1:0] loop_finish_addr;
    logic [CNT_W-1:0] loop_iterations_left;
  } zolc_setup_t;

  typedef struct packed {
    logic [ADDR_W-1:0] loop_begin_addr;
    logic [ADDR_W-1:0] loop_finish_addr;
    logic [CNT_W-1:0] loop_iterations_left;
  } zolc_set_t;

  typedef zolc_set_t [NUM_LOOPS-1:0] zolc_sets_t;

  localparam zolc_set_t SET_RESET = '{ADDR_RESET, ADDR_RESET, CNT_ZERO};

endpackage : zolc_pkg

//--- design/zolc_top.sv
// Zero-overhead loop controller with CSR view and AHB-Lite register slave
//
// Added by the designer: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/10ps

module zolc_top #(
  parameter bit LOOP_FEATURE_BUILD_PARAM = 1'b1,
  parameter logic [11:0] CSR_BASE = 12'hCC0
) (
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire zolc_pkg::zolc_setup_t setup_in,
  input wire logic exec_valid_in,
  input wire logic [31:0] exec_pc_in,
  input wire logic exec_cancel_in,
  output logic redirect_out,
  output logic [31:0] redirect_addr_out,
  input wire logic csr_rd_in,
  input wire logic csr_wr_in,
  input wire logic [11:0] csr_addr_in,
  output logic [31:0] csr_rdata_out,
  output logic csr_illegal_out,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic hreadyout_out,
  output logic hresp_out,
  output logic [31:0] hrdata_out,
  output logic irq_out
);

  function automatic logic [31:0] loop_word(
    input zolc_pkg::zolc_sets_t sets,
    input logic [zolc_pkg::CSR_IDX_W-1:0] idx
  );
    logic [31:0] w;
    w = zolc_pkg::WORD_ZERO;
    case (idx)
      zolc_pkg::IDX_BEGIN0: w = sets[0].loop_begin_addr;
      zolc_pkg::IDX_FINISH0: w = sets[0].loop_finish_addr;
      zolc_pkg::IDX_COUNT0: w = sets[0].loop_iterations_left;
      zolc_pkg::IDX_BEGIN1: w = sets[1].loop_begin_addr;
      zolc_pkg::IDX_FINISH1: w = sets[1].loop_finish_addr;
      zolc_pkg::IDX_COUNT1: w = sets[1].loop_iterations_left;
      default: w = zolc_pkg::WORD_ZERO;
    endcase
    return w;
  endfunction : loop_word

  function automatic logic set_active(input zolc_pkg::zolc_set_t s);
    return s.loop_iterations_left != zolc_pkg::CNT_ZERO;
  endfunction : set_active

  zolc_pkg::zolc_sets_t loops;
  zolc_pkg::zolc_sets_t next_loops;
  logic [zolc_pkg::IRQ_W-1:0] irq_status;
  logic [zolc_pkg::IRQ_W-1:0] irq_mask;
  logic [zolc_pkg::CTRL_W-1:0] ctrl;
  logic dp_write;
  logic [7:0] dp_addr;

  wire logic [zolc_pkg::NUM_LOOPS-1:0] at_last;
  wire logic [zolc_pkg::NUM_LOOPS-1:0] take;
  wire logic [zolc_pkg::NUM_LOOPS-1:0] loop_back;
  wire logic [zolc_pkg::NUM_LOOPS-1:0] loop_done;

  // Cancelled instruction neither counts nor redirects
  wire logic run = exec_valid_in && !exec_cancel_in && ctrl[zolc_pkg::CTRL_EN_BIT];

  for (genvar i = 0; i < zolc_pkg::NUM_LOOPS; i++)
  begin : g_loop
    // Final body instruction sits at finish - 4
    // Only a non-zero counter arms the loop
    assign at_last[i] = set_active(loops[i]) &&
      (exec_pc_in == (loops[i].loop_finish_addr - zolc_pkg::INSTR_BYTES));
    // Above one loops back, exactly one falls through
    assign loop_back[i] = take[i] && (loops[i].loop_iterations_left != zolc_pkg::CNT_ONE);
    assign loop_done[i] = take[i] && (loops[i].loop_iterations_left == zolc_pkg::CNT_ONE);
  end

  // Inner loop 0 shadows loop 1 on a shared end
  assign take[0] = run && at_last[0];
  assign take[1] = run && at_last[1] && !at_last[0];

  // Combinational redirect, fetch sees it same cycle
  assign redirect_out = |loop_back;
  // Target is the first body instruction
  assign redirect_addr_out = loop_back[0] ? loops[0].loop_begin_addr :
                             loops[1].loop_begin_addr;

  // Next loop state: setup from the core overrides a same-cycle decrement
  always_comb
  begin
    next_loops = loops;
    for (int i = 0; i < zolc_pkg::NUM_LOOPS; i++)
    begin
      // One count consumed per executed final instruction
      if (take[i])
      begin
        next_loops[i].loop_iterations_left =
          loops[i].loop_iterations_left - zolc_pkg::CNT_ONE;
      end
      if (setup_in.valid && (int'(setup_in.loop_sel) == i))
      begin
        case (setup_in.kind)
          zolc_pkg::ZOLC_SETUP_BEGIN:
            next_loops[i].loop_begin_addr = setup_in.loop_begin_addr;
          zolc_pkg::ZOLC_SETUP_FINISH:
            next_loops[i].loop_finish_addr = setup_in.loop_finish_addr;
          zolc_pkg::ZOLC_SETUP_COUNT:
            next_loops[i].loop_iterations_left = setup_in.loop_iterations_left;
          // All three words loaded in one cycle
          zolc_pkg::ZOLC_SETUP_ALL:
          begin
            next_loops[i].loop_begin_addr = setup_in.loop_begin_addr;
            next_loops[i].loop_finish_addr = setup_in.loop_finish_addr;
            next_loops[i].loop_iterations_left = setup_in.loop_iterations_left;
          end
          default: next_loops[i] = loops[i];
        endcase
      end
    end
  end

  // Loop sets exist only when the feature is built in
  if (LOOP_FEATURE_BUILD_PARAM)
  begin : g_sets
    // Two independent sets in separate flip-flops
    always_ff @(posedge sys_clk_in)
    begin
      if (srst_in)
      begin
        loops <= {zolc_pkg::NUM_LOOPS{zolc_pkg::SET_RESET}};
      end
      else
      begin
        loops <= next_loops;
      end
    end
  end
  else
  begin : g_no_sets
    assign loops = {zolc_pkg::NUM_LOOPS{zolc_pkg::SET_RESET}};
  end

  // CSR view of the loop sets
  wire logic [11:0] csr_offset = csr_addr_in - CSR_BASE;
  wire logic csr_hit = LOOP_FEATURE_BUILD_PARAM && (csr_offset < zolc_pkg::CSR_WORDS);
  wire logic [zolc_pkg::CSR_IDX_W-1:0] csr_idx = csr_offset[zolc_pkg::CSR_IDX_W-1:0];

  // Loop registers are read-only to CSR writes
  assign csr_illegal_out = csr_wr_in && csr_hit;

  // Loop sets readable through CSR space
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      csr_rdata_out <= zolc_pkg::WORD_ZERO;
    end
    else if (csr_rd_in)
    begin
      csr_rdata_out <= csr_hit ? loop_word(loops, csr_idx) : zolc_pkg::WORD_ZERO;
    end
  end

  // AHB-Lite slave: zero wait states, always OKAY
  wire logic ahb_take = hsel_in && htrans_in[1] && hready_in;
  wire logic [7:0] ahb_ofs = haddr_in[7:0];
  wire logic ahb_upper_zero = (haddr_in[31:8] == 24'h000000);
  wire logic ahb_loop_sel = ahb_upper_zero && (ahb_ofs <= zolc_pkg::OFS_LOOP_LAST) &&
    (ahb_ofs >= zolc_pkg::OFS_LOOP_FIRST);
  wire logic [zolc_pkg::CSR_IDX_W-1:0] ahb_idx = ahb_ofs[4:2];

  assign hreadyout_out = 1'b1;
  assign hresp_out = 1'b0;

  logic [31:0] ahb_rword;
  always_comb
  begin
    ahb_rword = zolc_pkg::WORD_ZERO;
    if (ahb_loop_sel)
    begin
      ahb_rword = loop_word(loops, ahb_idx);
    end
    else if (ahb_upper_zero && (ahb_ofs == zolc_pkg::OFS_IRQ_STATUS))
    begin
      ahb_rword = {29'h0000000, irq_status};
    end
    else if (ahb_upper_zero && (ahb_ofs == zolc_pkg::OFS_IRQ_MASK))
    begin
      ahb_rword = {29'h0000000, irq_mask};
    end
    else if (ahb_upper_zero && (ahb_ofs == zolc_pkg::OFS_CTRL))
    begin
      ahb_rword = {31'h00000000, ctrl};
    end
  end

  // Address phase capture and read data
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      dp_write <= 1'b0;
      dp_addr <= 8'h00;
      hrdata_out <= zolc_pkg::WORD_ZERO;
    end
    else
    begin
      dp_write <= ahb_take && hwrite_in && ahb_upper_zero;
      if (ahb_take)
      begin
        dp_addr <= ahb_ofs;
      end
      if (ahb_take && !hwrite_in)
      begin
        hrdata_out <= ahb_rword;
      end
    end
  end

  // Data-phase write decode
  wire logic wr_status = dp_write && (dp_addr == zolc_pkg::OFS_IRQ_STATUS);
  wire logic wr_mask = dp_write && (dp_addr == zolc_pkg::OFS_IRQ_MASK);
  wire logic wr_ctrl = dp_write && (dp_addr == zolc_pkg::OFS_CTRL);
  // Bus writes to loop words are dropped and flagged
  wire logic wr_loop = dp_write && (dp_addr <= zolc_pkg::OFS_LOOP_LAST);

  wire logic [zolc_pkg::IRQ_W-1:0] irq_set = {
    csr_illegal_out || wr_loop,
    loop_done[1],
    loop_done[0]
  };
  wire logic [zolc_pkg::IRQ_W-1:0] irq_clr =
    wr_status ? hwdata_in[zolc_pkg::IRQ_W-1:0] : 3'h0;

  // Sticky status, set beats a same-cycle write-one-to-clear
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      irq_status <= zolc_pkg::IRQ_STATUS_RESET;
      irq_mask <= zolc_pkg::IRQ_MASK_RESET;
      ctrl <= zolc_pkg::CTRL_RESET;
    end
    else
    begin
      irq_status <= (irq_status & ~irq_clr) | irq_set;
      if (wr_mask)
      begin
        irq_mask <= hwdata_in[zolc_pkg::IRQ_W-1:0];
      end
      if (wr_ctrl)
      begin
        ctrl <= hwdata_in[zolc_pkg::CTRL_W-1:0];
      end
    end
  end

  assign irq_out = |(irq_status & irq_mask);

endmodule : zolc_top

//--- test/tb.sv
// Self-checking bench for the loop controller
`timescale 1ns/10ps
module tb;
  localparam logic [11:0] CSR_BASE = 12'hCC0;
  logic clk = 1'b0;
  logic srst = 1'b1;
  zolc_pkg::zolc_setup_t setup = '0;
  logic run = 1'b0;
  logic cancel = 1'b0;
  logic csr_rd = 1'b0;
  logic csr_wr = 1'b0;
  logic [11:0] csr_addr = '0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = '0;
  logic [31:0] start = '0;
  logic [31:0] haddr = '0;
  logic [31:0] hwdata = '0;
  logic ev, redir, rdy, resp, ill, irq;
  logic [31:0] pc, raddr, crd, hrd, q, tgt, n, r;
  logic [31:0] redirs = '0;
  int mismatches = 0;
  int check_count = 0;
  always #4 clk = ~clk;
  always @(posedge clk) if (ev === 1'b1 && redir === 1'b1) redirs <= redirs + 32'h1;
  always @(posedge clk) if (ev === 1'b1 && redir === 1'b1) tgt <= raddr;
  zolc_top #(.CSR_BASE(CSR_BASE)) uut (.sys_clk_in(clk), .srst_in(srst), .setup_in(setup),
    .exec_valid_in(ev), .exec_pc_in(pc), .exec_cancel_in(cancel), .redirect_out(redir),
    .redirect_addr_out(raddr), .csr_rd_in(csr_rd), .csr_wr_in(csr_wr), .csr_addr_in(csr_addr),
    .csr_rdata_out(crd), .csr_illegal_out(ill), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
    .hready_in(rdy), .hreadyout_out(rdy), .hresp_out(resp), .hrdata_out(hrd), .irq_out(irq));
  zolc_fetch_model fm (.sys_clk_in(clk), .run_in(run), .start_in(start), .redirect_in(redir),
    .redirect_addr_in(raddr), .cancel_in(cancel), .valid_out(ev), .pc_out(pc));
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    check_count++;
    if (seen !== want)
    begin
      mismatches++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask : check
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    do @(posedge clk); while (rdy !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (rdy !== 1'b1);
    q = hrd;
  endtask : bus
  task automatic csr(input logic [2:0] i);
    @(posedge clk);
    csr_rd <= 1'b1;
    csr_addr <= CSR_BASE + {9'h0, i};
    @(posedge clk);
    csr_rd <= 1'b0;
    #1 q = crd;
  endtask : csr
  task automatic ld(input logic s, input zolc_pkg::zolc_setup_kind_t k, input logic [31:0] b,
    input logic [31:0] f, input logic [31:0] c);
    @(posedge clk);
    setup <= '{1'b1, s, k, b, f, c};
    @(posedge clk);
    setup.valid <= 1'b0;
  endtask : ld
  task automatic go(input logic [31:0] s, input logic [31:0] stop);
    @(posedge clk);
    run <= 1'b1;
    start <= s;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (!(ev === 1'b1 && pc === stop) && n < 99);
    run <= 1'b0;
  endtask : go
  task automatic t_reset;
    for (int i = 0; i < 6; i++)
    begin
      csr(i[2:0]);
      check(q, 32'h0);
    end
    bus(1'b0, 32'h20, 32'h0);
    check(q, 32'h1);
  endtask : t_reset
  task automatic t_single;
    ld(1'b0, zolc_pkg::ZOLC_SETUP_ALL, 32'h100, 32'h10C, 32'h3);
    r = redirs;
    go(32'h100, 32'h10C);
    check(n, 32'h0000000B);
    check(redirs - r, 32'h2);
    check(tgt, 32'h100);
    csr(3'h2);
    check(q, 32'h0);
  endtask : t_single
  task automatic t_nested;
    ld(1'b1, zolc_pkg::ZOLC_SETUP_BEGIN, 32'h200, 32'h0, 32'h0);
    ld(1'b1, zolc_pkg::ZOLC_SETUP_FINISH, 32'h0, 32'h20C, 32'h0);
    ld(1'b1, zolc_pkg::ZOLC_SETUP_COUNT, 32'h0, 32'h0, 32'h2);
    ld(1'b0, zolc_pkg::ZOLC_SETUP_ALL, 32'h204, 32'h20C, 32'h2);
    r = redirs;
    go(32'h200, 32'h20C);
    check(redirs - r, 32'h1);
    check(tgt, 32'h204);
    csr(3'h5);
    check(q, 32'h2);
    csr(3'h3);
    check(q, 32'h200);
  endtask : t_nested
  task automatic t_cancel;
    ld(1'b0, zolc_pkg::ZOLC_SETUP_ALL, 32'h100, 32'h10C, 32'h2);
    @(posedge clk);
    run <= 1'b1;
    start <= 32'h108;
    cancel <= 1'b1;
    repeat (2) @(posedge clk);
    check({31'h0, redir}, 32'h0);
    cancel <= 1'b0;
    @(posedge clk);
    check({31'h0, redir}, 32'h1);
    run <= 1'b0;
    csr(3'h2);
    check(q, 32'h1);
  endtask : t_cancel
  task automatic t_irq;
    @(posedge clk);
    csr_wr <= 1'b1;
    csr_addr <= CSR_BASE + 12'h5;
    #1 check({31'h0, ill}, 32'h1);
    @(posedge clk);
    csr_wr <= 1'b0;
    bus(1'b1, 32'h8, 32'h7);
    csr(3'h2);
    check(q, 32'h1);
    bus(1'b0, 32'h18, 32'h0);
    check(q, 32'h5);
    check({31'h0, irq}, 32'h0);
    bus(1'b1, 32'h1C, 32'h4);
    #1 check({31'h0, irq}, 32'h1);
    bus(1'b1, 32'h18, 32'h7);
    #1 check({31'h0, irq}, 32'h0);
  endtask : t_irq
  // Real nesting: loop 1 wraps loop 0 and redirects itself
  task automatic t_outer;
    ld(1'b1, zolc_pkg::ZOLC_SETUP_ALL, 32'h300, 32'h318, 32'h2);
    ld(1'b0, zolc_pkg::ZOLC_SETUP_ALL, 32'h304, 32'h30C, 32'h2);
    r = redirs;
    go(32'h300, 32'h318);
    check(n, 32'h10);
    check(redirs - r, 32'h2);
    check(tgt, 32'h300);
    csr(3'h5);
    check(q, 32'h0);
    bus(1'b0, 32'h18, 32'h0);
    check(q, 32'h3);
    check({31'h0, irq}, 32'h0);
  endtask : t_outer
  // Enable off, unmapped CSR read and write
  task automatic t_gate;
    bus(1'b1, 32'h20, 32'h0);
    ld(1'b0, zolc_pkg::ZOLC_SETUP_ALL, 32'h400, 32'h40C, 32'h2);
    r = redirs;
    go(32'h400, 32'h40C);
    check(n, 32'h5);
    check(redirs - r, 32'h0);
    csr(3'h2);
    check(q, 32'h2);
    bus(1'b1, 32'h20, 32'h1);
    @(posedge clk);
    csr_rd <= 1'b1;
    csr_addr <= CSR_BASE + 12'h8;
    @(posedge clk);
    csr_rd <= 1'b0;
    csr_wr <= 1'b1;
    csr_addr <= CSR_BASE + 12'h6;
    #1 check(crd, 32'h0);
    check({31'h0, ill}, 32'h0);
    @(posedge clk);
    csr_wr <= 1'b0;
    bus(1'b0, 32'h18, 32'h0);
    check(q, 32'h3);
  endtask : t_gate
  task automatic finish_test;
    if (mismatches == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : finish_test
  initial
  begin
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    t_single();
    t_nested();
    t_cancel();
    t_irq();
    t_outer();
    t_gate();
    finish_test();
  end
  initial
  begin
    #20000;
    mismatches++;
    finish_test();
  end
endmodule : tb
bind zolc_top zolc_sva #(.CSR_BASE(CSR_BASE)) u_sva (.sys_clk_in(sys_clk_in), .srst_in(srst_in),
  .exec_valid_in(exec_valid_in), .exec_cancel_in(exec_cancel_in), .redirect_out(redirect_out),
  .csr_rd_in(csr_rd_in), .csr_wr_in(csr_wr_in), .csr_addr_in(csr_addr_in),
  .csr_rdata_out(csr_rdata_out), .csr_illegal_out(csr_illegal_out),
  .hreadyout_out(hreadyout_out), .hresp_out(hresp_out));

//--- test/zolc_fetch_model.sv
// Fetch stage model stepping the executing address
`timescale 1ns/10ps
module zolc_fetch_model (
  input wire logic sys_clk_in,
  input wire logic run_in,
  input wire logic [31:0] start_in,
  input wire logic redirect_in,
  input wire logic [31:0] redirect_addr_in,
  input wire logic cancel_in,
  output logic valid_out,
  output logic [31:0] pc_out
);
  always_ff @(posedge sys_clk_in)
  begin
    valid_out <= run_in;
    if (valid_out !== 1'b1)
      pc_out <= start_in;
    else if (cancel_in)
      pc_out <= pc_out;
    else if (redirect_in)
      pc_out <= redirect_addr_in;
    else
      pc_out <= pc_out + 32'h0000_0004;
  end
endmodule : zolc_fetch_model

//--- test/zolc_sva.sv
// Port checks for the loop controller
`timescale 1ns/10ps
module zolc_sva #(
  parameter logic [11:0] CSR_BASE = 12'hCC0
) (
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic exec_valid_in,
  input wire logic exec_cancel_in,
  input wire logic redirect_out,
  input wire logic csr_rd_in,
  input wire logic csr_wr_in,
  input wire logic [11:0] csr_addr_in,
  input wire logic [31:0] csr_rdata_out,
  input wire logic csr_illegal_out,
  input wire logic hreadyout_out,
  input wire logic hresp_out
);
  wire logic in_range = csr_addr_in >= CSR_BASE && csr_addr_in <= CSR_BASE + 12'h5;
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (srst_in);
  property p_live;
    redirect_out |-> exec_valid_in && !exec_cancel_in;
  endproperty
  a_live: assert property (p_live) else $error("redirect without live instr");
  property p_ill;
    csr_wr_in && in_range |-> csr_illegal_out;
  endproperty
  a_ill: assert property (p_ill) else $error("csr write not flagged");
  property p_ill_src;
    csr_illegal_out |-> csr_wr_in && in_range;
  endproperty
  a_ill_src: assert property (p_ill_src) else $error("spurious illegal flag");
  property p_bus;
    hreadyout_out && !hresp_out;
  endproperty
  a_bus: assert property (p_bus) else $error("bus not ready or error");
  property p_quiet;
    $past(srst_in) |-> !redirect_out;
  endproperty
  a_quiet: assert property (p_quiet) else $error("redirect right after reset");
  property p_rd_zero;
    $past(srst_in) |-> csr_rdata_out == 32'h0;
  endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("csr data not cleared");
  property p_rd_hold;
    !$past(csr_rd_in) && !$past(srst_in) |-> $stable(csr_rdata_out);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("csr data moved");
  property p_rd_out;
    csr_rd_in && !in_range |=> csr_rdata_out == 32'h0;
  endproperty
  a_rd_out: assert property (p_rd_out) else $error("unmapped csr read");
endmodule : zolc_sva
